// ==== hdl/ewfe_front_end.sv ====
// slave-side two-wire bus front end of a serial eeprom
`timescale 1ns/100ps

module ewfe_front_end #(
  parameter int unsigned WRITE_CYCLES = ewfe_pkg::WRITE_CYCLES,
  parameter int unsigned FILT_LEN = ewfe_pkg::FILT_LEN
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic lclk,
  input wire logic porActive,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output ewfe_pkg::ewfe_rx_type rxWord,
  output logic standby,
  output logic writeBusy,
  output logic writeStart
);

  // =========================================================
  // link domain declarations
  logic sclF;
  logic sdaF;
  logic sclPrev_r;
  logic sdaPrev_r;
  logic startSeen;
  logic stopSeen;
  logic sclRise;
  logic sclFall;
  logic porLMeta_r;
  logic porL_r;
  logic busyLMeta_r;
  logic busyL_r;
  ewfe_pkg::ewfe_state_type state_r;
  logic [3:0] bitCnt_r;
  logic [ewfe_pkg::BYTE_BITS-1:0] shift_r;
  logic firstByte_r;
  logic writeDir_r;
  logic dataSeen_r;
  logic launchTgl_r;
  logic linkIdle_r;
  logic byteDone;

  // =========================================================
  // core domain declarations
  logic porMMeta_r;
  logic porM_r;
  logic tglMeta_r;
  logic tglSync_r;
  logic tglSeen_r;
  logic idleMeta_r;
  logic idleM_r;
  logic launchM;
  logic timerBusy;

  // =========================================================
  // pin conditioning
  ewfe_pin_filter #(
    .FILT_LEN(FILT_LEN)
  ) u_scl_filt (
    .clk(lclk),
    .nrst(nrst),
    .pinIn(sclIn),
    .pinFilt(sclF)
  );

  ewfe_pin_filter #(
    .FILT_LEN(FILT_LEN)
  ) u_sda_filt (
    .clk(lclk),
    .nrst(nrst),
    .pinIn(sdaIn),
    .pinFilt(sdaF)
  );

  // =========================================================
  // link domain: crossings in
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      porLMeta_r <= 1'b1;
      porL_r <= 1'b1;
    end else begin
      porLMeta_r <= porActive;
      porL_r <= porLMeta_r;
    end
  end

  // busy is a slow level, so a plain two-flop crossing is enough
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      busyLMeta_r <= 1'b0;
      busyL_r <= 1'b0;
    end else begin
      busyLMeta_r <= timerBusy;
      busyL_r <= busyLMeta_r;
    end
  end

  // =========================================================
  // link domain: edge and condition detection
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      sclPrev_r <= ewfe_pkg::LINE_IDLE;
      sdaPrev_r <= ewfe_pkg::LINE_IDLE;
    end else begin
      sclPrev_r <= sclF;
      sdaPrev_r <= sdaF;
    end
  end

  // data moving while clock is high is a condition, never a bit
  assign startSeen = sclF && sclPrev_r && sdaPrev_r && !sdaF; // [RULE9] [RULE11]
  assign stopSeen = sclF && sclPrev_r && !sdaPrev_r && sdaF; // [RULE9] [RULE12]
  assign sclRise = sclF && !sclPrev_r;
  assign sclFall = !sclF && sclPrev_r;
  assign byteDone = (state_r == ewfe_pkg::ST_BITS) && sclFall && (bitCnt_r == ewfe_pkg::BIT_LAST);

  // =========================================================
  // link domain: bus state machine
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ewfe_pkg::ST_IDLE;
    end else if (porL_r) begin
      state_r <= ewfe_pkg::ST_IDLE; // [RULE1] [RULE3]
    end else if (startSeen) begin
      // a busy device parks until the next start, so nothing of this frame is acked
      if (busyL_r) begin
        state_r <= ewfe_pkg::ST_IGNORE; // [RULE20]
      end else begin
        state_r <= ewfe_pkg::ST_BITS; // [RULE15]
      end
    end else if (stopSeen) begin
      state_r <= ewfe_pkg::ST_IDLE; // [RULE12] [RULE4]
    end else begin
      case (state_r)
        ewfe_pkg::ST_BITS: begin
          if (byteDone) begin
            state_r <= ewfe_pkg::ST_ACK;
          end
        end
        ewfe_pkg::ST_ACK: begin
          if (sclRise) begin
            state_r <= ewfe_pkg::ST_ACKHOLD;
          end
        end
        ewfe_pkg::ST_ACKHOLD: begin
          if (sclFall) begin
            state_r <= ewfe_pkg::ST_BITS;
          end
        end
        default: begin
          // idle and ignore wait for a start
          state_r <= state_r; // [RULE11]
        end
      endcase
    end
  end

  // =========================================================
  // link domain: bit counter and shifter
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      bitCnt_r <= ewfe_pkg::BIT_ZERO;
    end else if (porL_r || startSeen) begin
      bitCnt_r <= ewfe_pkg::BIT_ZERO; // [RULE15]
    end else if (state_r == ewfe_pkg::ST_ACKHOLD && sclFall) begin
      bitCnt_r <= ewfe_pkg::BIT_ZERO;
    end else if (state_r == ewfe_pkg::ST_BITS && sclRise && bitCnt_r != ewfe_pkg::BIT_LAST) begin
      bitCnt_r <= bitCnt_r + ewfe_pkg::BIT_ONE; // [RULE10]
    end
  end

  // sample on the rising edge, data is stable all through the high phase
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      shift_r <= '0;
    end else if (state_r == ewfe_pkg::ST_BITS && sclRise && bitCnt_r != ewfe_pkg::BIT_LAST && !porL_r) begin
      shift_r <= {shift_r[ewfe_pkg::BYTE_BITS-2:0], sdaF}; // [RULE10] [RULE8]
    end
  end

  // =========================================================
  // link domain: acknowledge drive, open drain only
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      sdaOe <= 1'b0;
    end else if (porL_r || startSeen || stopSeen) begin
      sdaOe <= 1'b0;
    end else if (byteDone) begin
      // pulled while clock is low, held over the ninth pulse
      sdaOe <= 1'b1; // [RULE19] [RULE14] [RULE8]
    end else if (state_r == ewfe_pkg::ST_ACKHOLD && sclFall) begin
      sdaOe <= 1'b0;
    end
  end

  // the line is only ever pulled low; high comes from the pull-up
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      sdaOut <= ewfe_pkg::SDA_LOW;
    end else begin
      sdaOut <= ewfe_pkg::SDA_LOW; // [RULE5]
    end
  end

  // =========================================================
  // link domain: received byte strobe
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      rxWord <= '0;
    end else if (byteDone && !porL_r) begin
      rxWord.data <= shift_r;
      rxWord.first <= firstByte_r;
      rxWord.valid <= 1'b1;
    end else begin
      rxWord.valid <= 1'b0;
    end
  end

  // =========================================================
  // link domain: transaction bookkeeping
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      firstByte_r <= 1'b1;
      writeDir_r <= 1'b0;
      dataSeen_r <= 1'b0;
    end else if (porL_r || startSeen || stopSeen) begin
      // a new start always expects an address byte
      firstByte_r <= 1'b1; // [RULE15]
      writeDir_r <= 1'b0;
      dataSeen_r <= 1'b0;
    end else if (byteDone) begin
      firstByte_r <= 1'b0;
      if (firstByte_r) begin
        writeDir_r <= (shift_r[ewfe_pkg::DIR_BIT] == ewfe_pkg::DIR_WRITE);
      end else if (writeDir_r) begin
        dataSeen_r <= 1'b1;
      end
    end
  end

  // only a stop after accepted write data launches the internal write
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      launchTgl_r <= 1'b0;
    end else if (stopSeen && !porL_r && !busyL_r && writeDir_r && dataSeen_r) begin
      launchTgl_r <= !launchTgl_r; // [RULE4] [RULE13]
    end
  end

  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      linkIdle_r <= 1'b1;
    end else begin
      linkIdle_r <= (state_r == ewfe_pkg::ST_IDLE) || (state_r == ewfe_pkg::ST_IGNORE);
    end
  end

  // =========================================================
  // core domain: crossings in
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      porMMeta_r <= 1'b1;
      porM_r <= 1'b1;
    end else begin
      porMMeta_r <= porActive;
      porM_r <= porMMeta_r;
    end
  end

  // toggle crossing keeps a single launch event from being lost or doubled
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tglMeta_r <= 1'b0;
      tglSync_r <= 1'b0;
      tglSeen_r <= 1'b0;
    end else begin
      tglMeta_r <= launchTgl_r;
      tglSync_r <= tglMeta_r;
      tglSeen_r <= tglSync_r;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      idleMeta_r <= 1'b1;
      idleM_r <= 1'b1;
    end else begin
      idleMeta_r <= linkIdle_r;
      idleM_r <= idleMeta_r;
    end
  end

  assign launchM = (tglSync_r != tglSeen_r) && !porM_r;

  // =========================================================
  // core domain: internal write cycle
  // power-on reset aborts the count so a half-done write never reports done
  ewfe_write_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_write_timer (
    .clk(mclk),
    .nrst(nrst),
    .start(launchM),
    .abort(porM_r),
    .busy(timerBusy)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      writeStart <= 1'b0;
    end else begin
      writeStart <= launchM && !timerBusy; // [RULE13]
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      writeBusy <= 1'b0;
    end else begin
      writeBusy <= timerBusy && !porM_r; // [RULE17] [RULE20]
    end
  end

  // =========================================================
  // core domain: standby
  // a launch still crossing counts as busy so standby never flickers
  // idle lags the launch toggle by a link cycle, so the launch always lands first
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      standby <= 1'b0;
    end else if (porM_r) begin
      standby <= 1'b0; // [RULE1]
    end else begin
      standby <= idleM_r && !timerBusy && !launchM; // [RULE2] [RULE3] [RULE4]
    end
  end

endmodule

// ==== pkg/ewfe_pkg.sv ====
// constants and types shared by the two-wire eeprom bus front end
// Operation
// RULE1: while power-on reset is active, all bus activity is ignored.
// RULE2: on power-on reset release, state machine initialises and enters standby.
// RULE3: power-on reset during power-down abandons any transaction, returns to standby.
// RULE4: after stop, standby at once, or after the launched write completes.
// RULE5: data line is open drain: pulled low or released, never driven high.
// RULE6: master makes every clock pulse, start and stop; device never drives clock.
// RULE7: master starts a transfer only on an idle bus after a stop.
// RULE8: transmitter keeps data stable while clock is high, changes it while low.
// RULE9: data change while clock is high is a start or stop, never data.
// RULE10: one bit per clock pulse, sampled while clock is high.
// RULE11: start is data falling while clock high; idle until one is seen.
// RULE12: stop is data rising while clock high; it ends the current operation.
// RULE13: master closes every operation with stop; only stop launches a write.
// RULE14: receiver acknowledges each good byte by pulling data low.
// RULE15: start mid-transaction aborts transfer, resyncs to expect an address byte.
// RULE16: master recovers by clocking up to nine times, then issuing start.
// RULE17: self-timed write launched by stop finishes within 5 ms, then standby.
// RULE18: master clock rate at most 400 KHz low supply, 1 MHz high supply.
// RULE19: accepted byte is acknowledged by pulling data low on the ninth pulse.
// RULE20: during an internal write every request is ignored and not acknowledged.
// RULE21: clock and data are synchronised and filtered before edge detection.
package ewfe_pkg;

  // =========================================================
  // timing
  localparam longint unsigned MCLK_HZ = 200_000_000;
  localparam longint unsigned WRITE_TIME_MS = 5;
  localparam int unsigned WRITE_CYCLES = int'((WRITE_TIME_MS * MCLK_HZ) / 1000);
  // glitch filter length in link clock cycles
  localparam int unsigned FILT_LEN = 3;

  // =========================================================
  // byte framing
  localparam int unsigned BYTE_BITS = 8;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam int unsigned DIR_BIT = 0;
  localparam logic DIR_WRITE = 1'b0;

  // =========================================================
  // reset values
  localparam logic LINE_IDLE = 1'b1;
  localparam logic SDA_LOW = 1'b0;

  // =========================================================
  // bus state machine, gray along idle -> bits -> ack -> ack hold
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BITS = 3'h1,
    ST_ACK = 3'h3,
    ST_ACKHOLD = 3'h2,
    ST_IGNORE = 3'h6
  } ewfe_state_type;

  typedef struct packed {
    logic [BYTE_BITS-1:0] data;
    logic first;
    logic valid;
  } ewfe_rx_type;

endpackage

// ==== hdl/ewfe_pin_filter.sv ====
// two-flop synchroniser followed by a stability filter for one bus pin
`timescale 1ns/100ps

module ewfe_pin_filter #(
  parameter int unsigned FILT_LEN = ewfe_pkg::FILT_LEN
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pinIn,
  output logic pinFilt
);

  localparam int unsigned CW = $clog2(FILT_LEN + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(FILT_LEN - 1);

  logic meta_r;
  logic sync_r;
  logic [CW-1:0] cnt_r;

  // =========================================================
  // synchroniser
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= ewfe_pkg::LINE_IDLE;
      sync_r <= ewfe_pkg::LINE_IDLE;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
    end
  end

  // =========================================================
  // level must hold FILT_LEN cycles before it is believed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      pinFilt <= ewfe_pkg::LINE_IDLE;
    end else if (sync_r == pinFilt) begin
      cnt_r <= '0;
    end else if (cnt_r == CNT_LAST) begin
      cnt_r <= '0;
      pinFilt <= sync_r; // [RULE21]
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

endmodule

// ==== hdl/ewfe_write_timer.sv ====
// self-timed write cycle counter
`timescale 1ns/100ps

module ewfe_write_timer #(
  parameter int unsigned CYCLES = ewfe_pkg::WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic abort,
  output logic busy
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      busy <= 1'b0;
    end else if (abort) begin
      cnt_r <= '0;
      busy <= 1'b0;
    end else if (start && !busy) begin
      cnt_r <= '0;
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt_r == CNT_LAST) begin
        busy <= 1'b0; // [RULE17]
      end
      cnt_r <= cnt_r + CW'(1);
    end
  end

endmodule

// ==== testbench/ewfe_front_end_asserts.sv ====
// port-level checks of the two-wire front end
`timescale 1ns/100ps
module ewfe_front_end_asserts #(
  parameter int unsigned WRITE_CYCLES = ewfe_pkg::WRITE_CYCLES,
  parameter int unsigned FILT_LEN = ewfe_pkg::FILT_LEN
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic lclk,
  input wire logic porActive,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire ewfe_pkg::ewfe_rx_type rxWord,
  input wire logic standby,
  input wire logic writeBusy,
  input wire logic writeStart
);
  // =====================================
  // write length counter
  int unsigned busyCnt_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busyCnt_r <= 0;
    end else if (writeStart) begin
      busyCnt_r <= 1;
    end else if (writeBusy) begin
      busyCnt_r <= busyCnt_r + 1;
    end
  end
  // =====================================
  // link side
  property p_openDrain;
    @(posedge lclk) disable iff (!nrst) sdaOut == 1'b0;
  endproperty
  a_openDrain: assert property (p_openDrain) else $error("data pin driven high");
  property p_porQuiet;
    @(posedge lclk) disable iff (!nrst) porActive [*6] |-> !sdaOe && !rxWord.valid;
  endproperty
  a_porQuiet: assert property (p_porQuiet) else $error("bus answered under reset");
  property p_ackWithByte;
    @(posedge lclk) disable iff (!nrst) rxWord.valid |-> sdaOe && !$past(sdaOe);
  endproperty
  a_ackWithByte: assert property (p_ackWithByte) else $error("byte without ack start");
  property p_ackHold;
    @(posedge lclk) disable iff (!nrst) $rose(sdaOe) |-> sdaOe [*8] ##[1:400] !sdaOe;
  endproperty
  a_ackHold: assert property (p_ackHold) else $error("ack pulse length wrong");
  // =====================================
  // core side, then covers of both sides
  property p_porCore;
    @(posedge mclk) disable iff (!nrst) porActive [*6] |-> !writeBusy && !standby;
  endproperty
  a_porCore: assert property (p_porCore) else $error("core active under reset");
  property p_busyLen;
    @(posedge mclk) disable iff (!nrst) $fell(writeBusy) && !porActive
      |-> busyCnt_r >= WRITE_CYCLES && busyCnt_r <= WRITE_CYCLES + 2;
  endproperty
  a_busyLen: assert property (p_busyLen) else $error("write length wrong");
  property p_busyNoStandby;
    @(posedge mclk) disable iff (!nrst) writeBusy |-> !standby;
  endproperty
  a_busyNoStandby: assert property (p_busyNoStandby) else $error("standby during write");
  property p_launch;
    @(posedge mclk) disable iff (!nrst) $rose(writeBusy) |-> writeStart || $past(writeStart);
  endproperty
  a_launch: assert property (p_launch) else $error("write without launch");
  property p_startBusy;
    @(posedge mclk) disable iff (!nrst) writeStart |-> ##[0:1] writeBusy;
  endproperty
  a_startBusy: assert property (p_startBusy) else $error("launch without busy");
  c_ack: cover property (@(posedge lclk) disable iff (!nrst) $rose(sdaOe));
  c_launch: cover property (@(posedge mclk) disable iff (!nrst) writeStart);
  c_standby: cover property (@(posedge mclk) disable iff (!nrst) $rose(standby));
endmodule

bind ewfe_front_end ewfe_front_end_asserts #(.WRITE_CYCLES(WRITE_CYCLES), .FILT_LEN(FILT_LEN)) u_chk (
  .mclk(mclk), .nrst(nrst), .lclk(lclk), .porActive(porActive), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .rxWord(rxWord), .standby(standby), .writeBusy(writeBusy),
  .writeStart(writeStart)
);

// ==== testbench/ewfe_mst.sv ====
// two-wire bus master model
`timescale 1ns/100ps
module ewfe_mst #(
  parameter int PH = 100
) (
  input wire logic mclk,
  input wire logic sdaLine,
  output logic sclOut,
  output logic sdaLow
);
  // master alone makes clock, start and stop
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  // phase of PH cycles keeps the pulse rate under 1 MHz
  task automatic hp();
    repeat (PH) @(posedge mclk);
  endtask
  // data moves only while clock low, one bit per pulse
  task automatic bitx(input logic v, output logic s);
    sdaLow <= ~v;
    hp();
    sclOut <= 1'b1;
    hp();
    s = sdaLine;
    sclOut <= 1'b0;
    hp();
  endtask
  // from idle or mid-transfer; tAbort and recover also call it mid-byte to abort a transfer
  task automatic start();
    sdaLow <= 1'b0;
    hp();
    sclOut <= 1'b1;
    hp();
    sdaLow <= 1'b1;
    hp();
    sclOut <= 1'b0;
    hp();
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    hp();
    sclOut <= 1'b1;
    hp();
    sdaLow <= 1'b0;
    hp();
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], s);
    end
    bitx(1'b1, ack);
  endtask
  task automatic drop();
    sclOut <= 1'b0;
    hp();
  endtask
  // up to nine pulses until data reads high, then start
  task automatic recover();
    logic s;
    for (int i = 0; i < 9; i++) begin
      bitx(1'b1, s);
      if (s) break;
    end
    start();
  endtask
endmodule

// ==== testbench/ewfe_front_end_tb.sv ====
// self-checking bench of the two-wire front end
`timescale 1ns/100ps
module ewfe_front_end_tb;
  localparam int WC = 6000;
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic nrst, porActive, glitch, sclLine, sdaLow, sdaOut, sdaOe, standby, writeBusy, writeStart;
  ewfe_pkg::ewfe_rx_type rxWord, lastW;
  int failCount = 0;
  int testsRun = 0;
  int nVal = 0;
  int nWs = 0;
  wire sdaLine = !sdaLow && (sdaOe ? sdaOut : 1'b1);
  always #2.5 mclk = ~mclk;
  initial begin
    #3.1;
    forever #7.5 lclk = ~lclk;
  end
  ewfe_mst u_ewfe_mst (.mclk(mclk), .sdaLine(sdaLine), .sclOut(sclLine), .sdaLow(sdaLow));
  ewfe_front_end #(.WRITE_CYCLES(WC)) u_ewfe_front_end (
    .mclk(mclk), .nrst(nrst), .lclk(lclk), .porActive(porActive), .sclIn(sclLine ^ glitch),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .rxWord(rxWord), .standby(standby),
    .writeBusy(writeBusy), .writeStart(writeStart)
  );
  always @(posedge lclk) if (rxWord.valid === 1'b1) begin
    nVal <= nVal + 1;
    lastW <= rxWord;
  end
  always @(posedge mclk) if (writeStart === 1'b1) nWs <= nWs + 1;
  // =====================================
  // helpers
  task automatic closeOut();
    $display("checks %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xbyte(input logic [7:0] b, input logic noAck);
    int n0;
    logic a;
    n0 = nVal;
    u_ewfe_mst.sendByte(b, a);
    chk(a, noAck);
    chk(nVal - n0, !noAck);
    if (!noAck) chk(lastW.data, b);
  endtask
  task automatic waitIdle();
    for (int n = 0; standby !== 1'b1; n++) begin
      @(posedge mclk);
      if (n > WC + 100) begin
        failCount++;
        closeOut();
      end
    end
  endtask
  // =====================================
  // scenarios
  task automatic tPor();
    u_ewfe_mst.start();
    xbyte(8'ha0, 1'b1);
    u_ewfe_mst.stop();
    chk(standby, 0);
    porActive <= 1'b0;
    repeat (40) @(posedge mclk);
    chk(standby, 1);
    u_ewfe_mst.drop();
    xbyte(8'h5a, 1'b1);
    u_ewfe_mst.stop();
  endtask
  task automatic tWrite();
    int n0;
    n0 = nWs;
    u_ewfe_mst.start();
    xbyte(8'ha0, 1'b0);
    chk(lastW.first, 1);
    fork
      xbyte(8'h5c, 1'b0);
      begin
        // short clock spike while low must not count as a bit
        repeat (50) @(posedge mclk);
        glitch <= 1'b1;
        repeat (2) @(posedge mclk);
        glitch <= 1'b0;
      end
    join
    chk(lastW.first, 0);
    u_ewfe_mst.stop();
    repeat (20) @(posedge mclk);
    chk(nWs - n0, 1);
    chk({writeBusy, standby}, 2'h2);
    u_ewfe_mst.start();
    xbyte(8'ha0, 1'b1);
    u_ewfe_mst.stop();
    waitIdle();
  endtask
  task automatic tAbort();
    int n0;
    logic a;
    n0 = nWs;
    u_ewfe_mst.start();
    for (int i = 0; i < 4; i++) u_ewfe_mst.bitx(1'b0, a);
    u_ewfe_mst.start();
    xbyte(8'ha0, 1'b0);
    chk(lastW.first, 1);
    for (int i = 0; i < 3; i++) u_ewfe_mst.bitx(1'b0, a);
    u_ewfe_mst.stop();
    repeat (40) @(posedge mclk);
    chk(standby, 1);
    chk(nWs - n0, 0);
  endtask
  task automatic tPorMid();
    int n0;
    logic a;
    n0 = nWs;
    u_ewfe_mst.start();
    xbyte(8'h3c, 1'b0);
    u_ewfe_mst.bitx(1'b0, a);
    porActive <= 1'b1;
    repeat (40) @(posedge mclk);
    chk(standby, 0);
    porActive <= 1'b0;
    repeat (40) @(posedge mclk);
    chk(standby, 1);
    xbyte(8'hff, 1'b1);
    u_ewfe_mst.recover();
    xbyte(8'hc3, 1'b0);
    u_ewfe_mst.stop();
    chk(nWs - n0, 0);
  endtask
  initial begin
    nrst = 1'b0;
    porActive = 1'b1;
    glitch = 1'b0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (20) @(posedge mclk);
    tPor();
    tWrite();
    tAbort();
    tPorMid();
    closeOut();
  end
endmodule
